/* File: hdl/power_mode_pkg.sv */
package power_mode_pkg;
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_MODE_STATUS = 8'h02;
  localparam logic [7:0] POWER_MODE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
  localparam int IDLE_SEL_BIT = 0;
  localparam int STOP_SEL_BIT = 1;
  localparam int SOFT_FLAGS_LSB = 2;
  localparam int SOFT_FLAGS_MSB = 7;
  localparam int STOP_SHUTDOWN_BIT = 3;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_STOP = 2'b10
  } power_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic watchdog;
    logic missing_clock;
    logic supply_monitor;
    logic comparator;
    logic pin;
  } reset_src_t;
endpackage

/* File: hdl/idle_stop_power_mode_control.sv */
// Contract
// - idle bit write halts core after instruction
// - idle keeps oscillator, peripherals, contents alive; core clock gated
// - enabled interrupt ends idle, clears bit
// - resume after the idle-setting instruction
// - reset ends idle, restart at zero
// - watchdog reset still ends idle
// - stop bit write enters stop after instruction
// - stop halts oscillator, core, digital peripherals
// - only reset ends stop, restart zero
// - missing clock detector reset ends stop
// - regulator on in stop by default
// - shutdown setting: only pin or power
// - stop and idle bits read zero
// - bits 7:2 plain software flags
// - unused digital peripherals clock gated off
// - shutdown setting is regulator control bit 3
`timescale 1ns/1ps
`default_nettype none
module idle_stop_power_mode_control
  import power_mode_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire reset_src_t reset_req,
  input wire logic [7:0] periph_in_use,
  output logic core_run,
  output logic core_clk_en,
  output logic [7:0] periph_clk_en,
  output logic int_osc_en,
  output logic regulator_en,
  output logic device_reset,
  output logic [15:0] restart_vector,
  output logic [1:0] mode
);
  reg_req_t req;
  power_mode_t state;
  power_mode_t next_state;
  logic [5:0] soft_flags;
  logic stop_shutdown;
  logic pend_idle;
  logic pend_stop;
  logic [7:0] next_rdata;
  // reset pin stages
  logic pin_sync1;
  logic pin_sync2;
  logic pin_sync3;
  logic pin_level;
  // next output values
  logic next_core_run;
  logic next_core_clk_en;
  logic next_osc_en;
  logic next_regulator_en;
  logic [7:0] next_periph_clk_en;
  logic [1:0] next_mode;
  logic next_pend_idle;
  logic next_pend_stop;

  // register decode shared by the write and read paths
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // the flag field of the power mode word
  function automatic logic [5:0] flag_field(input logic [7:0] word);
    return word[SOFT_FLAGS_MSB:SOFT_FLAGS_LSB];
  endfunction

  // true for the mode that halts the oscillator
  function automatic logic is_stop(input power_mode_t m);
    return m == MODE_STOP;
  endfunction

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // address selects
  wire sel_pmc = addr_is(req.addr, ADDR_POWER_MODE_CONTROL);
  wire sel_reg = addr_is(req.addr, ADDR_REGULATOR_CONTROL);
  wire sel_status = addr_is(req.addr, ADDR_MODE_STATUS);
  wire wr_pmc = req.wr && sel_pmc;
  wire wr_reg = req.wr && sel_reg;
  // select bits of a power mode write
  wire req_idle = wr_pmc && req.wdata[IDLE_SEL_BIT];
  wire req_stop = wr_pmc && req.wdata[STOP_SEL_BIT];
  wire idle_wake = (state == MODE_IDLE) && irq_pending;
  wire [7:0] pmc_word = {soft_flags, 2'b00};
  wire [7:0] status_word = {6'h00, state};

  // reset pin comes from outside the clock domain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_sync3 <= 1'b0;
    end else begin
      pin_sync1 <= reset_req.pin;
      pin_sync2 <= pin_sync1;
      pin_sync3 <= pin_sync2;
    end
  end

  // level moves once the last two stages agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_level <= 1'b0;
    end else if (pin_sync2 == pin_sync3) begin
      pin_level <= pin_sync3;
    end
  end

  // stop wakes only from reset; a shut regulator leaves only the pin
  wire any_reset = pin_level || reset_req.watchdog || reset_req.missing_clock ||
                   reset_req.supply_monitor || reset_req.comparator;
  wire stop_reset = stop_shutdown ? pin_level : any_reset;
  wire wake_reset = is_stop(state) ? stop_reset : any_reset;

  // requests wait until the writing instruction has completed
  wire go_stop = (pend_stop || req_stop) && instr_done;
  wire go_idle = (pend_idle || req_idle) && instr_done;

  // mode sequence
  always_comb begin
    next_state = state;
    case (state)
      MODE_RUN: begin
        if (go_stop) begin
          next_state = MODE_STOP;
        end else if (go_idle) begin
          next_state = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (idle_wake) begin
          next_state = MODE_RUN;
        end
      end
      MODE_STOP: begin
        next_state = MODE_STOP;
      end
      default: begin
        next_state = MODE_RUN;
      end
    endcase
  end

  // current mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MODE_RUN;
    end else if (wake_reset) begin
      state <= MODE_RUN;
    end else begin
      state <= next_state;
    end
  end

  // a request seen before the instruction ends is held until it does
  assign next_pend_idle = (state == MODE_RUN) && !instr_done && (pend_idle || req_idle);
  assign next_pend_stop = (state == MODE_RUN) && !instr_done && (pend_stop || req_stop);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_idle <= 1'b0;
      pend_stop <= 1'b0;
    end else if (wake_reset) begin
      pend_idle <= 1'b0;
      pend_stop <= 1'b0;
    end else begin
      pend_idle <= next_pend_idle;
      pend_stop <= next_pend_stop;
    end
  end

  // software flags survive idle, not reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_flags <= POWER_MODE_CONTROL_RESET[SOFT_FLAGS_MSB:SOFT_FLAGS_LSB];
    end else if (wake_reset) begin
      soft_flags <= flag_field(POWER_MODE_CONTROL_RESET);
    end else if (wr_pmc) begin
      soft_flags <= flag_field(req.wdata);
    end
  end

  // regulator setting
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_shutdown <= REGULATOR_CONTROL_RESET[STOP_SHUTDOWN_BIT];
    end else if (wake_reset) begin
      stop_shutdown <= REGULATOR_CONTROL_RESET[STOP_SHUTDOWN_BIT];
    end else if (wr_reg) begin
      stop_shutdown <= req.wdata[STOP_SHUTDOWN_BIT];
    end
  end

  // select bits always read zero; other addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (sel_pmc) begin
      next_rdata = pmc_word;
    end else if (sel_reg) begin
      next_rdata[STOP_SHUTDOWN_BIT] = stop_shutdown;
    end else if (sel_status) begin
      next_rdata = status_word;
    end
  end

  // read data stands the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // levels follow the mode being entered; a wake forces run
  assign next_core_run = (next_state == MODE_RUN) || wake_reset;
  assign next_core_clk_en = next_core_run;
  assign next_osc_en = !is_stop(next_state) || wake_reset;
  // idle keeps peripherals clocked, stop halts them, unused ones gated
  assign next_periph_clk_en = (is_stop(next_state) && !wake_reset) ? 8'h00 : periph_in_use;
  assign next_regulator_en = !(is_stop(next_state) && stop_shutdown && !wake_reset);
  assign next_mode = wake_reset ? MODE_RUN : next_state;

  // core halt
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_run <= 1'b1;
    end else begin
      core_run <= next_core_run;
    end
  end

  // core clock gate
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_clk_en <= 1'b1;
    end else begin
      core_clk_en <= next_core_clk_en;
    end
  end

  // peripheral clock gates
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      periph_clk_en <= 8'h00;
    end else begin
      periph_clk_en <= next_periph_clk_en;
    end
  end

  // internal oscillator
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_osc_en <= 1'b1;
    end else begin
      int_osc_en <= next_osc_en;
    end
  end

  // core regulator
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regulator_en <= 1'b1;
    end else begin
      regulator_en <= next_regulator_en;
    end
  end

  // normal reset sequence request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= wake_reset;
    end
  end

  // visible mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign restart_vector = RESET_VECTOR;
endmodule
`default_nettype wire

/* File: tb/pm_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pm_sva
  import power_mode_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire reset_src_t reset_req,
  input wire logic core_run,
  input wire logic int_osc_en,
  input wire logic regulator_en,
  input wire logic device_reset,
  input wire logic [1:0] mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire calm = reset_req == 5'h00;
  wire go = reg_wr && reg_addr == ADDR_POWER_MODE_CONTROL && instr_done && mode == MODE_RUN && calm;
  chk_idle_entry: assert property (go && reg_wdata[1:0] == 2'h1 |=> mode == MODE_IDLE) else $error("no idle");
  chk_stop_entry: assert property (go && reg_wdata[1] |=> mode == MODE_STOP) else $error("no stop");
  chk_idle_clks: assert property (mode == MODE_IDLE |-> int_osc_en && !core_run) else $error("idle clk");
  chk_stop_halt: assert property (mode == MODE_STOP |-> !int_osc_en && !core_run) else $error("stop clk");
  chk_idle_wake: assert property (mode == MODE_IDLE && irq_pending && calm |=> mode == MODE_RUN) else $error("wake");
  chk_pin_ends: assert property ($rose(reset_req.pin) && mode != MODE_RUN |->
    ##[4:6] device_reset && mode == MODE_RUN) else $error("pin");
  chk_stop_holds: assert property (mode == MODE_STOP && !reset_req.pin && (calm || !regulator_en) |=>
    mode == MODE_STOP) else $error("left stop");
  chk_dog_idle: assert property (mode == MODE_IDLE && reset_req.watchdog |=> device_reset) else $error("dog");
  cover property (mode == MODE_IDLE && irq_pending);
  cover property (mode == MODE_STOP && !regulator_en);
  cover property (device_reset);
endmodule
bind idle_stop_power_mode_control pm_sva i_chk(.*);
`default_nettype wire

/* File: tb/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic core_clk,
  input wire logic core_run,
  output logic instr_done = 1'b0
);
  // an instruction completes every cycle, one cycle after the core runs
  always @(posedge core_clk) instr_done <= core_run;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import power_mode_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_pending = 1'b0;
  logic instr_done, core_run, core_clk_en, int_osc_en, regulator_en, device_reset;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, periph_in_use = 8'h05, reg_rdata, periph_clk_en;
  logic [15:0] restart_vector;
  logic [1:0] mode;
  reset_src_t reset_req = 5'h00;
  int errors = 0, n_tests = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  idle_stop_power_mode_control i_dut(.*);
  core_model i_core(.core_clk, .core_run, .instr_done);
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata", e, reg_rdata);
  endtask
  task automatic wm(logic [1:0] m);
    @(negedge core_clk);
    for (int i = 0; i < 20 && mode !== m; i++) @(negedge core_clk);
    chk("mode", m, mode);
  endtask
  task automatic finish_test();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(ADDR_POWER_MODE_CONTROL, 8'h00);
    rd(ADDR_REGULATOR_CONTROL, 8'h00);
    chk("periph", 8'h05, periph_clk_en);
    chk("vector", RESET_VECTOR, restart_vector);
    @(posedge core_clk);
    periph_in_use <= 8'h0A;
    repeat (2) @(negedge core_clk);
    chk("gating", 8'h0A, periph_clk_en);
    wr(ADDR_POWER_MODE_CONTROL, 8'hFD);
    wm(MODE_IDLE);
    chk("clocks", 11'h10A, {core_run, core_clk_en, int_osc_en, periph_clk_en});
    rd(ADDR_POWER_MODE_CONTROL, 8'hFC);
    rd(ADDR_MODE_STATUS, 8'h01);
    @(posedge core_clk);
    irq_pending <= 1'b1;
    wm(MODE_RUN);
    @(posedge core_clk);
    irq_pending <= 1'b0;
    wr(ADDR_POWER_MODE_CONTROL, 8'hFD);
    wm(MODE_IDLE);
    @(posedge core_clk);
    reset_req.watchdog <= 1'b1;
    wm(MODE_RUN);
    chk("reset", 1'b1, device_reset);
    @(posedge core_clk);
    reset_req <= 5'h00;
    rd(ADDR_POWER_MODE_CONTROL, 8'h00);
    wr(ADDR_POWER_MODE_CONTROL, 8'h03);
    wm(MODE_STOP);
    chk("stop", 12'h001, {core_run, core_clk_en, int_osc_en, periph_clk_en, regulator_en});
    @(posedge core_clk);
    irq_pending <= 1'b1;
    repeat (10) @(negedge core_clk);
    chk("mode", MODE_STOP, mode);
    @(posedge core_clk);
    irq_pending <= 1'b0;
    reset_req.missing_clock <= 1'b1;
    wm(MODE_RUN);
    @(posedge core_clk);
    reset_req <= 5'h00;
    wr(ADDR_REGULATOR_CONTROL, 8'h08);
    rd(ADDR_REGULATOR_CONTROL, 8'h08);
    wr(ADDR_POWER_MODE_CONTROL, 8'h02);
    wm(MODE_STOP);
    chk("regulator", 1'b0, regulator_en);
    @(posedge core_clk);
    reset_req.watchdog <= 1'b1;
    repeat (10) @(negedge core_clk);
    chk("mode", MODE_STOP, mode);
    @(posedge core_clk);
    reset_req.pin <= 1'b1;
    wm(MODE_RUN);
    chk("reset", 1'b1, device_reset);
    @(posedge core_clk);
    reset_req <= 5'h00;
    repeat (8) @(posedge core_clk);
    rd(ADDR_REGULATOR_CONTROL, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
